// file: rtl/bmrp_pkg.sv
// Operation
// R1: Slow filter gives 16-bit current every 250 ms
// R2: Fast filter gives 24-bit current, 3/1.5 ms
// R3: Fast raw word sign-extends 24 bits to 32
// R4: Fast current also reported scaled to 16 bits
// R5: Average of up to 255 fast samples, 32-bit
// R6: Charge is 64 bits, integer over fraction
// R7: Integration time counts whole seconds, 32 bits
// R8: Reset command clears charge and time
// R9: Charging current reads positive
// R10: Each cell voltage stored with synchronous current
// R11: General input full scale 1.6667 reference volts
// R12: First thermistor pin raw count is readable
// R13: Die temperature reported, routed by configuration
// R14: Pull-up choice 18k, 180k or none
// R15: Per-pin thermistor, pull-up and usage configuration
// R16: Thermistor temperature from programmable polynomial
// R17: Raw voltage word has offset trim removed
// R18: Reported millivolts carry trim and gain
// R19: Host validates sleep first-cell readings against neighbours
// R20: Host spaces sleep reads beyond measurement interval
// R21: Host distrusts low reading without comparator alert
// R22: Spurious low reading cannot latch permanent fail
// R23: Cell voltages reported 16-bit in millivolts
package bmrp_pkg;
  // Timing
  localparam int CLK_KHZ       = 10_000;
  localparam int FAST_US       = 3000;
  localparam int FAST_HALF_US  = 1500;
  localparam int SLOW_MS       = 250;
  localparam int SEC_MS        = 1000;
  localparam int FAST_CYC_DEF  = FAST_US * CLK_KHZ / 1000;
  localparam int HALF_CYC_DEF  = FAST_HALF_US * CLK_KHZ / 1000;
  localparam int SLOW_CYC_DEF  = SLOW_MS * CLK_KHZ;
  localparam int SEC_CYC_DEF   = SEC_MS * CLK_KHZ;
  // Scaling
  localparam int SLOW_SHIFT     = 8;
  localparam int SCALE_SHIFT    = 8;
  localparam int CHG_FRAC_SHIFT = 16;
  localparam logic [15:0] CELL_GAIN  = 16'h2F58;
  localparam logic [15:0] GENERAL_ANALOG_INPUT_GAIN = 16'h0FC8;
  localparam logic [15:0] DIE_GAIN   = 16'h1000;
  localparam logic [15:0] DIE_OFS    = 16'h0B1C;
  localparam logic [31:0] VOFS_TRIM  = 32'h0000_0000;
  // Slots
  localparam int NCELL = 16;
  localparam int NPIN  = 3;
  localparam logic [4:0] SLOT_DIE  = 5'h10;
  localparam logic [4:0] SLOT_PIN0 = 5'h11;
  // Word offsets
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_CMD    = 6'h01;
  localparam logic [5:0] REG_SLOW   = 6'h02;
  localparam logic [5:0] REG_FRAW   = 6'h03;
  localparam logic [5:0] REG_FSCL   = 6'h04;
  localparam logic [5:0] REG_AVG    = 6'h05;
  localparam logic [5:0] REG_CHGI   = 6'h06;
  localparam logic [5:0] REG_CHGF   = 6'h07;
  localparam logic [5:0] REG_TIME   = 6'h08;
  localparam logic [5:0] REG_STAT   = 6'h09;
  localparam logic [5:0] REG_SUV    = 6'h0A;
  localparam logic [5:0] REG_GENERAL_ANALOG_INPUT  = 6'h0B;
  localparam logic [5:0] REG_TS1RAW = 6'h0C;
  localparam logic [5:0] REG_DIE    = 6'h0D;
  localparam logic [5:0] REG_TEMPS  = 6'h0E;
  localparam logic [5:0] REG_TSCFG  = 6'h0F;
  localparam logic [5:0] REG_COEF0  = 6'h10;
  localparam logic [1:0] PAIR_SEL   = 2'h2;
  localparam logic [1:0] RAW_SEL    = 2'h3;
  // Reset values
  localparam logic [15:0] CTRL_RST  = 16'h0100;
  localparam logic [23:0] SUV_RST   = 24'h02_0000;
  localparam logic [11:0] TSCFG_RST = 12'h000;
  localparam logic [63:0] COEF_RST  = 64'h0000_0000_0000_0000;
  // Types
  typedef enum logic [1:0] {
    PULL_NONE = 2'b00,
    PULL_18K  = 2'b01,
    PULL_180K = 2'b10
  } bmrp_pull_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bmrp_bus_t;
  typedef struct packed {
    logic [4:0]  slot;
    logic [23:0] raw;
  } bmrp_vsample_t;
  typedef struct packed {
    logic       fet;
    bmrp_pull_t pull;
    logic       therm;
  } bmrp_ts_cfg_t;
endpackage

// file: rtl/bmrp_top.sv
`timescale 1ns/1ps
`default_nettype none
module bmrp_top #(
  parameter int FAST_CYC = bmrp_pkg::FAST_CYC_DEF,
  parameter int HALF_CYC = bmrp_pkg::HALF_CYC_DEF,
  parameter int SLOW_CYC = bmrp_pkg::SLOW_CYC_DEF,
  parameter int SEC_CYC  = bmrp_pkg::SEC_CYC_DEF
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    cc_sample_vld,
  input  wire logic [15:0]             cc_sample,
  input  wire logic                    vs_vld,
  input  wire bmrp_pkg::bmrp_vsample_t vs,
  output logic [2:0]                   pu18_en,
  output logic [2:0]                   pu180_en,
  output logic                         suv_alert,
  output logic                         pf_fault,
  output logic [15:0]                  cell_temp,
  output logic [15:0]                  fet_temp,
  output logic [15:0]                  slow_current,
  output logic                         fast_done,
  output logic                         slow_done
);
  import bmrp_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [23:0] sat24(input logic signed [31:0] v);
    if (v > 32'sh007F_FFFF) return 24'h7F_FFFF;
    else if (v < -32'sh0080_0000) return 24'h80_0000;
    else return v[23:0];
  endfunction

  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh0000_0000_7FFF) return 16'h7FFF;
    else if (v < -48'sh0000_0000_8000) return 16'h8000;
    else return v[15:0];
  endfunction

  // Gain times count over 65536
  function automatic logic [15:0] scale(input logic [15:0] g, input logic [15:0] c);
    logic signed [32:0] p;
    p = $signed({1'b0, g}) * $signed(c);
    return p[31:16];
  endfunction

  // Horner evaluation, coefficients c3 in top slice
  function automatic logic [15:0] poly(input logic [15:0] x, input logic [63:0] c);
    logic signed [31:0] y;
    logic signed [31:0] p;
    y = {{16{c[63]}}, c[63:48]};
    p = 32'sh0;
    for (int k = 2; k >= 0; k--) begin
      p = $signed(y[15:0]) * $signed(x);
      y = (p >>> 15) + {{16{c[k*16+15]}}, c[k*16+:16]};
    end
    return y[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Registers and state
  bmrp_bus_t          bus_ff;
  logic [31:0]        rd_ff, nxt_rd;
  logic [15:0]        ctrl_ff;
  logic [23:0]        suv_cfg_ff;
  logic [11:0]        ts_cfg_ff;
  logic [63:0]        coef_ff;
  logic [31:0]        frac_shadow_ff;
  logic [23:0]        fast_cnt_ff, slow_cnt_ff, sec_cnt_ff, suv_pre_ff;
  logic signed [31:0] fast_acc_ff;
  logic signed [47:0] slow_acc_ff;
  logic [23:0]        fast_res_ff;
  logic [15:0]        slow_res_ff;
  logic               fast_done_ff, slow_done_ff;
  logic signed [31:0] avg_sum_ff, avg_res_ff;
  logic [7:0]         avg_cnt_ff, suv_sec_ff;
  logic signed [63:0] chg_ff;
  logic [31:0]        time_ff;
  logic               suv_alert_ff, pf_ff;
  logic [31:0]        pair_ff [NCELL];
  logic [31:0]        cell_raw_ff [NCELL];
  logic [15:0]        general_analog_input_ff, die_ff, cell_temp_ff, fet_temp_ff;
  logic [31:0]        ts1_raw_ff;

  logic wr_now, clr_chg, clr_pf, half, sec_tick;
  logic [23:0] fast_last;
  logic [7:0]  avg_n;
  logic [15:0] fast_scaled;

  // Bus write strobes and control fields
  assign wr_now  = (bus_ff == BUS_DONE) && avs_write;
  assign clr_chg = wr_now && (avs_address == REG_CMD) && avs_writedata[0]; // see R8
  assign clr_pf  = wr_now && (avs_address == REG_CMD) && avs_writedata[1];
  assign half    = ctrl_ff[0];
  assign avg_n   = (ctrl_ff[15:8] == 8'h00) ? 8'h01 : ctrl_ff[15:8];

  ////////////////////////////////////////////////////////////////
  // Avalon slave, one wait state per access
  assign avs_waitrequest = (avs_read || avs_write) && (bus_ff == BUS_IDLE);
  assign avs_readdata    = rd_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_ff         <= BUS_IDLE;
      rd_ff          <= 32'h0000_0000;
      frac_shadow_ff <= 32'h0000_0000;
    end else begin
      unique case (bus_ff)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_ff <= BUS_DONE;
            rd_ff  <= avs_read ? nxt_rd : 32'h0000_0000;
            if (avs_read && (avs_address == REG_CHGI)) begin
              frac_shadow_ff <= chg_ff[31:0]; // Coherent 64-bit pair, see R6
            end
          end
        end
        BUS_DONE: begin
          bus_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read decode, unmapped words read zero
  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (avs_address[5:4] == PAIR_SEL) begin
      nxt_rd = pair_ff[avs_address[3:0]]; // see R10
    end else if (avs_address[5:4] == RAW_SEL) begin
      nxt_rd = cell_raw_ff[avs_address[3:0]]; // see R17
    end else begin
      case (avs_address)
        REG_CTRL:   nxt_rd = {16'h0000, ctrl_ff};
        REG_SLOW:   nxt_rd = {{16{slow_res_ff[15]}}, slow_res_ff};
        REG_FRAW:   nxt_rd = {{8{fast_res_ff[23]}}, fast_res_ff}; // see R3
        REG_FSCL:   nxt_rd = {{16{fast_scaled[15]}}, fast_scaled};
        REG_AVG:    nxt_rd = avg_res_ff;
        REG_CHGI:   nxt_rd = chg_ff[63:32];
        REG_CHGF:   nxt_rd = frac_shadow_ff;
        REG_TIME:   nxt_rd = time_ff;
        REG_STAT:   nxt_rd = {30'h0, pf_ff, suv_alert_ff};
        REG_SUV:    nxt_rd = {8'h00, suv_cfg_ff};
        REG_GENERAL_ANALOG_INPUT:  nxt_rd = {16'h0000, general_analog_input_ff};
        REG_TS1RAW: nxt_rd = ts1_raw_ff; // see R12
        REG_DIE:    nxt_rd = {16'h0000, die_ff};
        REG_TEMPS:  nxt_rd = {fet_temp_ff, cell_temp_ff};
        REG_TSCFG:  nxt_rd = {20'h0_0000, ts_cfg_ff};
        default: begin
          if (avs_address[5:2] == REG_COEF0[5:2]) begin
            nxt_rd = {16'h0000, coef_ff[avs_address[1:0]*16+:16]};
          end
        end
      endcase
    end
  end

  // Software configuration
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= CTRL_RST;
      suv_cfg_ff <= SUV_RST;
      ts_cfg_ff  <= TSCFG_RST;
      coef_ff    <= COEF_RST;
    end else if (wr_now) begin
      if (avs_address == REG_CTRL) ctrl_ff <= avs_writedata[15:0];
      if (avs_address == REG_SUV) suv_cfg_ff <= avs_writedata[23:0];
      if (avs_address == REG_TSCFG) ts_cfg_ff <= avs_writedata[11:0]; // see R15
      if (avs_address[5:2] == REG_COEF0[5:2]) begin
        coef_ff[avs_address[1:0]*16+:16] <= avs_writedata[15:0]; // see R16
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Fast filter: sum of samples over one period
  assign fast_last   = half ? 24'(HALF_CYC - 1) : 24'(FAST_CYC - 1);
  assign fast_scaled = fast_res_ff[23:SCALE_SHIFT]; // see R4
  assign fast_done   = fast_done_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_cnt_ff  <= 24'h00_0000;
      fast_acc_ff  <= 32'sh0;
      fast_res_ff  <= 24'h00_0000;
      fast_done_ff <= 1'b0;
    end else begin
      fast_done_ff <= 1'b0;
      if (fast_cnt_ff >= fast_last) begin
        fast_cnt_ff  <= 24'h00_0000;
        fast_acc_ff  <= cc_sample_vld ? 32'($signed(cc_sample)) : 32'sh0;
        // Half period sum doubled, then saturated to 24 bits
        fast_res_ff  <= sat24(half ? fast_acc_ff <<< 1 : fast_acc_ff); // see R2
        fast_done_ff <= 1'b1;
      end else begin
        fast_cnt_ff <= fast_cnt_ff + 24'h00_0001;
        if (cc_sample_vld) fast_acc_ff <= fast_acc_ff + 32'($signed(cc_sample)); // see R9
      end
    end
  end

  // Slow filter: long sum for charge integration
  assign slow_current = slow_res_ff;
  assign slow_done    = slow_done_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_cnt_ff  <= 24'h00_0000;
      slow_acc_ff  <= 48'sh0;
      slow_res_ff  <= 16'h0000;
      slow_done_ff <= 1'b0;
    end else begin
      slow_done_ff <= 1'b0;
      if (slow_cnt_ff == 24'(SLOW_CYC - 1)) begin
        slow_cnt_ff  <= 24'h00_0000;
        slow_acc_ff  <= cc_sample_vld ? 48'($signed(cc_sample)) : 48'sh0;
        slow_res_ff  <= sat16(slow_acc_ff >>> SLOW_SHIFT); // see R1
        slow_done_ff <= 1'b1;
      end else begin
        slow_cnt_ff <= slow_cnt_ff + 24'h00_0001;
        if (cc_sample_vld) slow_acc_ff <= slow_acc_ff + 48'($signed(cc_sample));
      end
    end
  end

  // Averaging filter over programmable fast result count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avg_sum_ff <= 32'sh0;
      avg_cnt_ff <= 8'h00;
      avg_res_ff <= 32'sh0;
    end else if (fast_done_ff) begin
      if ({1'b0, avg_cnt_ff} + 9'h001 >= {1'b0, avg_n}) begin
        avg_res_ff <= (avg_sum_ff + 32'($signed(fast_res_ff))) /
                      $signed({24'h00_0000, avg_n}); // see R5
        avg_sum_ff <= 32'sh0;
        avg_cnt_ff <= 8'h00;
      end else begin
        avg_sum_ff <= avg_sum_ff + 32'($signed(fast_res_ff));
        avg_cnt_ff <= avg_cnt_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Passed charge and integration time
  assign sec_tick = (sec_cnt_ff == 24'(SEC_CYC - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chg_ff     <= 64'sh0;
      time_ff    <= 32'h0000_0000;
      sec_cnt_ff <= 24'h00_0000;
    end else if (clr_chg) begin
      chg_ff     <= 64'sh0; // see R8
      time_ff    <= 32'h0000_0000;
      sec_cnt_ff <= 24'h00_0000;
    end else begin
      sec_cnt_ff <= sec_tick ? 24'h00_0000 : sec_cnt_ff + 24'h00_0001;
      if (sec_tick) time_ff <= time_ff + 32'h0000_0001; // see R7
      if (slow_done_ff) begin
        chg_ff <= chg_ff + (64'($signed(slow_res_ff)) <<< CHG_FRAC_SHIFT); // see R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Voltage result correction
  logic signed [31:0] v_corr;
  logic [15:0]        v_cnt, v_mv;
  logic [4:0]         pin_slot;
  logic [3:0]         v_idx;
  bmrp_ts_cfg_t       pin_cfg;

  assign v_corr   = $signed({{8{vs.raw[23]}}, vs.raw}) - $signed(VOFS_TRIM); // see R17
  assign v_cnt    = v_corr[23:8];
  assign v_mv     = scale(CELL_GAIN, v_cnt); // see R18
  assign pin_slot = vs.slot - SLOT_PIN0;
  assign v_idx    = vs.slot[3:0];
  assign pin_cfg  = bmrp_ts_cfg_t'(ts_cfg_ff[pin_slot[1:0]*4+:4]);

  // Cell results paired with the simultaneous current
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCELL; i++) begin
        pair_ff[i]     <= 32'h0000_0000;
        cell_raw_ff[i] <= 32'h0000_0000;
      end
    end else if (vs_vld && (vs.slot < 5'(NCELL))) begin
      pair_ff[v_idx]     <= {fast_scaled, v_mv}; // see R10 see R23
      cell_raw_ff[v_idx] <= v_corr;
    end
  end

  // Die temperature and multifunction pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      die_ff       <= 16'h0000;
      general_analog_input_ff     <= 16'h0000;
      ts1_raw_ff   <= 32'h0000_0000;
      cell_temp_ff <= 16'h0000;
      fet_temp_ff  <= 16'h0000;
    end else if (vs_vld) begin
      if (vs.slot == SLOT_DIE) begin
        die_ff <= scale(DIE_GAIN, v_cnt) + DIE_OFS; // see R13
        if (ctrl_ff[1]) fet_temp_ff <= scale(DIE_GAIN, v_cnt) + DIE_OFS;
        else cell_temp_ff <= scale(DIE_GAIN, v_cnt) + DIE_OFS;
      end else if (vs.slot >= SLOT_PIN0 && pin_slot < 5'(NPIN)) begin
        if (pin_slot == 5'h00) ts1_raw_ff <= {{8{vs.raw[23]}}, vs.raw}; // see R12
        if (pin_cfg.therm) begin
          if (pin_cfg.fet) fet_temp_ff <= poly(v_cnt, coef_ff); // see R16
          else cell_temp_ff <= poly(v_cnt, coef_ff); // see R15
        end else begin
          general_analog_input_ff <= scale(GENERAL_ANALOG_INPUT_GAIN, v_cnt); // see R11
        end
      end
    end
  end

  assign cell_temp = cell_temp_ff;
  assign fet_temp  = fet_temp_ff;

  // Bias pull-up selection per pin
  for (genvar p = 0; p < NPIN; p++) begin : g_pull
    bmrp_ts_cfg_t c;
    assign c           = bmrp_ts_cfg_t'(ts_cfg_ff[p*4+:4]);
    assign pu18_en[p]  = c.therm && (c.pull == PULL_18K); // see R14
    assign pu180_en[p] = c.therm && (c.pull == PULL_180K);
  end

  ////////////////////////////////////////////////////////////////
  // Safety undervoltage on the first cell
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      suv_alert_ff <= 1'b0;
    end else if (vs_vld && vs.slot == 5'h00) begin
      suv_alert_ff <= $signed(v_mv) < $signed(suv_cfg_ff[15:0]);
    end
  end

  // Alert must persist a full qualifying time before fail latches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      suv_pre_ff <= 24'h00_0000;
      suv_sec_ff <= 8'h00;
    end else if (!suv_alert_ff) begin
      suv_pre_ff <= 24'h00_0000; // see R22
      suv_sec_ff <= 8'h00;
    end else if (suv_pre_ff == 24'(SEC_CYC - 1)) begin
      suv_pre_ff <= 24'h00_0000;
      if (suv_sec_ff != 8'hFF) suv_sec_ff <= suv_sec_ff + 8'h01;
    end else begin
      suv_pre_ff <= suv_pre_ff + 24'h00_0001;
    end
  end

  // Sticky fail, a new set wins over a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pf_ff <= 1'b0;
    end else if (suv_alert_ff && suv_sec_ff >= suv_cfg_ff[23:16]) begin
      pf_ff <= 1'b1; // see R22
    end else if (clr_pf) begin
      pf_ff <= 1'b0;
    end
  end

  assign suv_alert = suv_alert_ff;
  assign pf_fault  = pf_ff;

  ////////////////////////////////////////////////////////////////
  // Checks
  logic [23:0] fgap_ff, sgap_ff;

  // Cycles since the previous filter result, the result cycle counted as one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fgap_ff <= 24'h00_0000;
      sgap_ff <= 24'h00_0000;
    end else begin
      fgap_ff <= fast_done_ff ? 24'h00_0001 : fgap_ff + 24'h00_0001;
      sgap_ff <= slow_done_ff ? 24'h00_0001 : sgap_ff + 24'h00_0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 (bus_ff == BUS_IDLE);
  endsequence

  chk_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus access not answered after one wait state");
  chk_slow_period: assert property (slow_done_ff |-> sgap_ff == 24'(SLOW_CYC)) // see R1
    else $error("slow result spacing wrong");
  chk_fast_period: assert property (fast_done_ff |-> fgap_ff <= 24'(FAST_CYC)) // see R2
    else $error("fast result spacing too long");
  chk_fast_sext: assert property ((bus_ff == BUS_DONE) && avs_read && avs_address == REG_FRAW
      |-> avs_readdata[31:24] == {8{avs_readdata[23]}}) // see R3
    else $error("fast raw word not sign extended");
  chk_avg_single: assert property (fast_done_ff && avg_n == 8'h01
      |=> avg_res_ff == 32'($signed($past(fast_res_ff)))) // see R5
    else $error("single sample average wrong");
  chk_charge_add: assert property (slow_done_ff && !clr_chg |=> chg_ff ==
      $past(chg_ff) + (64'($signed($past(slow_res_ff))) <<< CHG_FRAC_SHIFT)) // see R6
    else $error("charge not integrated");
  chk_time_tick: assert property (sec_tick && !clr_chg // see R7
      |=> time_ff == $past(time_ff) + 1)
    else $error("time counter missed a second");
  chk_clear_cmd: assert property (clr_chg |=> chg_ff == 64'sh0 && time_ff == 32'h0) // see R8
    else $error("reset command did not clear");
  chk_pair_capture: assert property (vs_vld && vs.slot < 5'(NCELL)
      |=> pair_ff[$past(v_idx)][31:16] == $past(fast_scaled)) // see R10
    else $error("cell current pair not captured");
  chk_pull_excl: assert property ((pu18_en & pu180_en) == 3'b000) // see R14
    else $error("both pull-ups enabled");
  chk_pf_qualified: assert property ($rose(pf_ff) |-> $past(suv_alert_ff) &&
      ($past(suv_cfg_ff[23:16]) == 8'h00 || $past(suv_sec_ff) != 8'h00)) // see R22
    else $error("fail latched without qualified alert");
endmodule
`default_nettype wire

// file: verification/bmrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module bmrp_host (
  input  wire logic        clk_sys,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Bus idle from time zero
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
  end
  //////////////////////////////////////////////////////////////
  // One bus cycle, held until waitrequest is sampled low
  task automatic xfer(input bit w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask
  // Sleep reading of cell 0, judged by neighbours read one interval apart
  function automatic bit cell0_ok(int p, int c, int n, bit low_no_alert);
    if (low_no_alert) return 1'h0;
    return (c - p) ** 2 < 2500 || (c - n) ** 2 < 2500;
  endfunction
endmodule
`default_nettype wire

// file: verification/bmrp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module bmrp_top_test;
  import bmrp_pkg::*;
  localparam int FC = 30, HC = 15, SC = 200, TC = 100;
  logic          clk_sys, rst, cc_sample_vld, vs_vld, avs_read, avs_write;
  logic          avs_waitrequest, suv_alert, pf_fault, fast_done, slow_done;
  logic [5:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, q;
  logic [15:0]   cc_sample, cell_temp, fet_temp, slow_current;
  logic [2:0]    pu18_en, pu180_en;
  bmrp_vsample_t vs;
  int            num_errors, cmp_count, cyc, s, fast;
  bmrp_top #(.FAST_CYC(FC), .HALF_CYC(HC), .SLOW_CYC(SC), .SEC_CYC(TC)) bmrp_top_i (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .cc_sample_vld, .cc_sample, .vs_vld, .vs,
    .pu18_en, .pu180_en, .suv_alert, .pf_fault, .cell_temp, .fet_temp,
    .slow_current, .fast_done, .slow_done);
  bmrp_host bmrp_host_i (.clk_sys, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  // Clock and cycle count
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////
  // Comparison, bus and stimulus helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bmrp_host_i.xfer(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bmrp_host_i.xfer(1'h1, a, d, q);
  endtask
  task automatic wdone(input bit sl, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((sl ? slow_done : fast_done) !== 1'h1);
  endtask
  task automatic sendv(input logic [4:0] sl, input logic [23:0] r);
    vs     <= '{slot: sl, raw: r};
    vs_vld <= 1'h1;
    @(posedge clk_sys);
    vs_vld <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  function automatic int mv(input int g, input logic [23:0] r);
    return (g * int'($signed(r[23:8]))) >>> 16;
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int          m, c, n, t0, x;
    int          cf[4];
    shortint     y;
    longint      ch;
    logic [23:0] r;
    {num_errors, cmp_count, cyc} = '0;
    {vs_vld, vs} = '0;
    rst = 1'h1;
    cc_sample_vld = 1'h1;
    void'($urandom(29878));
    s = int'($urandom_range(4000)) - 2000;
    fast = s * FC;
    cc_sample = 16'(s);
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rd_chk(REG_CTRL, 32'(CTRL_RST));
    rd_chk(REG_SUV, 32'(SUV_RST));
    rd_chk(6'h14, 32'h0);
    // Fast filter, full and half rate, and the average
    wdone(1'h0, n);
    wdone(1'h0, n);
    chk(32'(n), 32'(FC));
    rd_chk(REG_FRAW, 32'(fast));
    rd_chk(REG_FSCL, 32'(fast >>> 8));
    wr(REG_CTRL, 32'h0000_0301);
    wdone(1'h0, n);
    wdone(1'h0, n);
    chk(32'(n), 32'(HC));
    rd_chk(REG_FRAW, 32'(fast));
    repeat (5 * HC) @(posedge clk_sys);
    rd_chk(REG_AVG, 32'(fast));
    // Slow filter period and value
    wdone(1'h1, n);
    wdone(1'h1, n);
    chk(32'(n), 32'(SC));
    m = (s * SC) >>> 8;
    chk(32'(slow_current), 32'(16'(m)));
    rd_chk(REG_SLOW, 32'(m));
    // Clear, then two slow results enter the charge
    wr(REG_CMD, 32'h1);
    t0 = cyc;
    rd_chk(REG_CHGI, 32'h0);
    rd_chk(REG_TIME, 32'h0);
    wdone(1'h1, n);
    wdone(1'h1, n);
    repeat (2) @(posedge clk_sys);
    ch = (longint'(m) * 2) <<< 16;
    rd_chk(REG_CHGI, ch[63:32]);
    rd_chk(REG_CHGF, ch[31:0]);
    bmrp_host_i.xfer(1'h0, REG_TIME, 32'h0, q);
    chk(32'((q - 32'((cyc - t0) / TC) + 32'h1) <= 32'h2), 32'h1);
    // Paired voltage and current, corrected and raw
    for (int i = 0; i < 4; i++) begin
      c = $urandom_range(15);
      r = 24'($urandom_range(24'h7FFFFF));
      sendv(5'(c), r);
      rd_chk(6'h20 + 6'(c), {16'(fast >>> 8), 16'(mv(12120, r))});
      rd_chk(6'h30 + 6'(c), 32'(r));
    end
    // General input, raw pin count and die temperature routing
    sendv(SLOT_PIN0, r);
    rd_chk(REG_GENERAL_ANALOG_INPUT, 32'(mv(4040, r)));
    rd_chk(REG_TS1RAW, 32'(r));
    sendv(SLOT_DIE, r);
    m = mv(4096, r) + 2844;
    chk(32'(cell_temp), 32'(16'(m)));
    rd_chk(REG_DIE, 32'(m));
    wr(REG_CTRL, 32'h0000_0302);
    sendv(SLOT_DIE, r);
    chk(32'(fet_temp), 32'(16'(m)));
    // Sleep cell 0: a fresh sample before each read, the middle one a spike
    for (int k = 0; k < 3; k++) begin
      sendv(5'h0, (k == 1) ? 24'h10_0000 : 24'h40_0000);
      bmrp_host_i.xfer(1'h0, 6'h20, 32'h0, q);
      cf[k] = int'(q[15:0]);
    end
    chk(32'(cf[2]), 32'(mv(12120, 24'h40_0000)));
    chk(32'(bmrp_host_i.cell0_ok(cf[0], cf[1], cf[2], 1'h0)), 32'h0);
    chk(32'(bmrp_host_i.cell0_ok(cf[1], cf[2], cf[0], 1'h0)), 32'h1);
    chk(32'(bmrp_host_i.cell0_ok(cf[1], cf[2], cf[0], 1'h1)), 32'h0);
    // Pull-ups, thermistor use and polynomial
    wr(REG_TSCFG, 32'h053);
    rd_chk(REG_TSCFG, 32'h053);
    chk(32'({pu18_en, pu180_en}), 32'h0A);
    for (int k = 0; k < 4; k++) begin
      cf[k] = $urandom_range(1000);
      wr(REG_COEF0 + 6'(k), 32'(cf[k]));
    end
    sendv(SLOT_PIN0, r);
    x = int'($signed(r[23:8]));
    y = shortint'(cf[3]);
    for (int k = 2; k >= 0; k--) y = shortint'(((y * x) >>> 15) + cf[k]);
    chk(32'(cell_temp), 32'(16'(y)));
    // Short low reading must not latch; a long one must
    wr(REG_SUV, 32'h0001_0800);
    sendv(5'h0, 24'h0);
    chk(32'({suv_alert, pf_fault}), 32'h2);
    repeat (50) @(posedge clk_sys);
    sendv(5'h0, 24'h7FFFFF);
    chk(32'({suv_alert, pf_fault}), 32'h0);
    sendv(5'h0, 24'h0);
    repeat (250) @(posedge clk_sys);
    rd_chk(REG_STAT, 32'h3);
    sendv(5'h0, 24'h7FFFFF);
    wr(REG_CMD, 32'h2);
    rd_chk(REG_STAT, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
